// >>> rtl/adc_dev_end.sv
// converter end of the two-wire link: conversion timing, readout, sleep, calibration
`timescale 1ns/1ps
module adc_dev_end
  import adc_link_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  adc_link_if.dev link,
  input wire logic [WORD_W-1:0] sample_data,
  output logic conv_done,
  output logic filt_rst,
  output logic cal_busy,
  output logic asleep
);

  // ****************************************************************
  // link clock domain: rising edge pointer
  // ****************************************************************
  logic [5:0] gptr_s;
  // gray count of sclk rises; async clear as sclk may be stopped in reset
  always_ff @(posedge link.sclk or negedge nrst)
  begin
    if (!nrst)
      gptr_s <= EDGE_RST;
    else
      gptr_s <= bin2gray(gray2bin(gptr_s) + 6'h01);
  end

  // ****************************************************************
  // crossing into the system clock domain
  // ****************************************************************
  logic [5:0] gp1_q;
  logic [5:0] gp2_q;
  logic sclk_lvl;
  logic lvl_q;
  logic [5:0] ptr;
  logic [5:0] base_q;
  logic [5:0] edges;
  // two-flop pointer synchroniser; the sclk level lags the pointer, so keep it to see its fall
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      gp1_q <= EDGE_RST;
      gp2_q <= EDGE_RST;
      lvl_q <= 1'b0;
    end
    else if (ce)
    begin
      gp1_q <= gptr_s;
      gp2_q <= gp1_q;
      lvl_q <= sclk_lvl;
    end
  end
  // sclk level seen as a pin for phase timing
  pin_sync3 #(
    .RST(1'b0)
  ) u_sclk_sync (
    .clk(clk),
    .nrst(nrst),
    .ce(ce),
    .d(link.sclk),
    .q(sclk_lvl)
  );
  // rises since the last counter clear
  assign ptr = gray2bin(gp2_q);
  assign edges = ptr - base_q;

  // ****************************************************************
  // control state machine
  // ****************************************************************
  dev_state_t state_q;
  dev_state_t state_d;
  logic [11:0] tmr_q;
  logic [11:0] hold_q;
  logic avail_q;
  logic cal_wake_q;
  logic single_q;
  logic [WORD_W-1:0] data_q;
  logic tmr_done;
  logic conv_end;
  logic leave;

  assign tmr_done = (state_q == DS_CAL) ? (tmr_q == CAL_CYC - 12'h001)
                                        : (tmr_q == CONV_CYC - 12'h001);
  assign leave = (state_d != state_q);
  assign conv_end = (state_q == DS_RUN) && !leave && tmr_done;
  // next state from timers and sclk phases
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      DS_CAL:
      begin
        if (tmr_done)
          state_d = DS_RUN; // convert, then ready falls
      end
      DS_RUN:
      begin
        if (avail_q && sclk_lvl && (hold_q >= SLEEP_CYC))
          state_d = DS_SLEEP;
        else if ((edges >= EDGE_CAL) && lvl_q && !sclk_lvl)
          state_d = DS_CAL; // falling edge of 26th pulse
      end
      DS_SLEEP:
      begin
        if (!sclk_lvl)
          state_d = cal_wake_q ? DS_CAL : DS_RUN;
      end
      default:
        state_d = DS_CAL;
    endcase
  end
  // state register; every reset starts with a calibration
  always_ff @(posedge clk)
  begin
    if (!nrst)
      state_q <= DS_CAL;
    else if (ce)
      state_q <= state_d;
  end
  // conversion / calibration timer, restarted on every state change
  always_ff @(posedge clk)
  begin
    if (!nrst)
      tmr_q <= CNT_RST;
    else if (ce)
    begin
      if (leave || tmr_done || (state_q == DS_SLEEP))
        tmr_q <= CNT_RST;
      else
        tmr_q <= tmr_q + 12'h001;
    end
  end
  // sclk high time, counted in the system clock domain
  always_ff @(posedge clk)
  begin
    if (!nrst)
      hold_q <= CNT_RST;
    else if (ce)
    begin
      if (!sclk_lvl || (state_q != DS_RUN))
        hold_q <= CNT_RST;
      else if (hold_q != SLEEP_CYC)
        hold_q <= hold_q + 12'h001;
    end
  end

  // ****************************************************************
  // result latch and bit counter clear
  // ****************************************************************
  // newest result always replaces the held one
  always_ff @(posedge clk)
  begin
    if (!nrst)
      data_q <= '0;
    else if (ce && conv_end)
      data_q <= sample_data;
  end
  // counter base: clear on latch, sleep, calibration and reset
  always_ff @(posedge clk)
  begin
    if (!nrst)
      base_q <= EDGE_RST; // pointer also clears in reset
    else if (ce && (conv_end || leave))
      base_q <= ptr;
  end
  // result available until the run state is left
  always_ff @(posedge clk)
  begin
    if (!nrst)
      avail_q <= 1'b0;
    else if (ce)
    begin
      if (conv_end)
        avail_q <= 1'b1;
      else if (leave)
        avail_q <= 1'b0;
    end
  end
  // calibrate on wake when the 26th pulse was the one held high
  always_ff @(posedge clk)
  begin
    if (!nrst)
      cal_wake_q <= 1'b0;
    else if (ce && (state_d == DS_SLEEP) && leave)
      cal_wake_q <= (edges >= EDGE_CAL);
  end
  // single-conversion mark: first conversion after a wake
  always_ff @(posedge clk)
  begin
    if (!nrst)
      single_q <= 1'b0;
    else if (ce)
    begin
      if ((state_q == DS_SLEEP) && leave)
        single_q <= 1'b1;
      else if (conv_end)
        single_q <= 1'b0;
    end
  end

  // ****************************************************************
  // ready/data output
  // ****************************************************************
  logic rdy_q;
  logic [4:0] bit_idx;

  assign bit_idx = 5'(EDGE_LAST_BIT - edges);
  assign link.rdy_dout = rdy_q;
  // idle high, low on new result, then one bit per sclk rise
  always_ff @(posedge clk)
  begin
    if (!nrst)
      rdy_q <= 1'b1;
    else if (ce)
    begin
      if (state_d != DS_RUN)
        rdy_q <= 1'b1;
      else if (conv_end)
        rdy_q <= 1'b0; // held low until sclk rises
      else if (!avail_q)
        rdy_q <= 1'b1;
      else if ((edges != EDGE_RST) && (edges <= EDGE_LAST_BIT))
        rdy_q <= data_q[bit_idx]; // msb first
      else if (edges >= EDGE_IDLE)
        rdy_q <= 1'b1; // 25th edge, else last bit holds
    end
  end

  // ****************************************************************
  // user-side status
  // ****************************************************************
  // flags and pulses, all registered
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      conv_done <= 1'b0;
      filt_rst <= 1'b0;
      cal_busy <= 1'b1;
      asleep <= 1'b0;
    end
    else if (ce)
    begin
      conv_done <= conv_end;
      filt_rst <= conv_end && single_q;
      cal_busy <= (state_d == DS_CAL);
      asleep <= (state_d == DS_SLEEP);
    end
  end
endmodule

// >>> rtl/adc_host_end.sv
// host end of the two-wire link: makes sclk by division and reads results
`timescale 1ns/1ps
module adc_host_end
  import adc_link_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  adc_link_if.host link,
  input wire logic cmd_valid,
  input wire logic [1:0] cmd_op,
  output logic cmd_ready,
  output logic [WORD_W-1:0] result,
  output logic result_valid,
  output logic sleeping
);

  // pulse on which an operation ends
  function automatic logic [5:0] last_edge(input logic [1:0] op);
    unique case (op)
      OP_READ: return EDGE_IDLE;
      OP_READ_CAL: return EDGE_CAL;
      OP_READ_SLEEP: return EDGE_LAST_BIT;
      OP_READ_CAL_SLEEP: return EDGE_IDLE;
    endcase
  endfunction

  host_state_t state_q;
  logic [1:0] op_q;
  logic [7:0] div_q;
  logic [5:0] pulse_q;
  logic sclk_q;
  logic rdy_lvl;
  logic [WORD_W-1:0] shift_q;
  logic take;
  logic phase_end;

  assign link.sclk = sclk_q;
  assign take = cmd_valid && cmd_ready;
  assign phase_end = (div_q == HALF_CYC - 8'h01);

  // ready/data is foreign to this clock
  pin_sync3 #(
    .RST(1'b1)
  ) u_rdy_sync (
    .clk(clk),
    .nrst(nrst),
    .ce(ce),
    .d(link.rdy_dout),
    .q(rdy_lvl)
  );

  // ****************************************************************
  // sclk sequencer
  // ****************************************************************

  // phases of sclk; sleep lies in a held high phase, calibration in the pulse count
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      state_q <= HS_IDLE;
      sclk_q <= 1'b0;
      pulse_q <= EDGE_RST;
      op_q <= OP_READ;
    end
    else if (ce)
    begin
      unique case (state_q)
        HS_IDLE:
        begin
          if (take)
          begin
            op_q <= cmd_op;
            pulse_q <= EDGE_RST;
            state_q <= HS_WAIT;
          end
        end
        HS_WAIT:
        begin
          if (!rdy_lvl)
          begin
            sclk_q <= 1'b1; // only once ready is seen low
            pulse_q <= pulse_q + 6'h01;
            state_q <= HS_HIGH;
          end
        end
        HS_HIGH:
        begin
          if (phase_end)
          begin
            sclk_q <= 1'b0;
            state_q <= HS_LOW;
          end
        end
        HS_LOW:
        begin
          if (phase_end)
          begin
            if (pulse_q != last_edge(op_q))
            begin
              sclk_q <= 1'b1;
              pulse_q <= pulse_q + 6'h01;
              state_q <= HS_HIGH;
            end
            else if (op_q[1])
            begin
              sclk_q <= 1'b1; // held high: sleep
              state_q <= HS_HOLD;
            end
            else
              state_q <= HS_IDLE; // 25th or 26th fall ends the read; the 26th starts calibration
          end
        end
        HS_HOLD:
        begin
          if (take)
          begin
            sclk_q <= 1'b0; // wake
            state_q <= HS_IDLE;
          end
        end
        default:
          state_q <= HS_IDLE;
      endcase
    end
  end

  // phase timer
  always_ff @(posedge clk)
  begin
    if (!nrst)
      div_q <= 8'h00;
    else if (ce)
    begin
      if (((state_q == HS_HIGH) || (state_q == HS_LOW)) && !phase_end)
        div_q <= div_q + 8'h01;
      else
        div_q <= 8'h00;
    end
  end

  // ****************************************************************
  // data capture and user outputs
  // ****************************************************************

  // sample each bit at the end of its low phase, msb first
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      shift_q <= '0;
      result <= '0;
      result_valid <= 1'b0;
    end
    else if (ce)
    begin
      result_valid <= 1'b0;
      if ((state_q == HS_LOW) && phase_end && (pulse_q <= EDGE_LAST_BIT))
      begin
        shift_q <= {shift_q[WORD_W-2:0], rdy_lvl};
        if (pulse_q == EDGE_LAST_BIT)
        begin
          result <= {shift_q[WORD_W-2:0], rdy_lvl};
          result_valid <= 1'b1;
        end
      end
    end
  end

  // command acceptance and sleep flag
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      cmd_ready <= 1'b0;
      sleeping <= 1'b0;
    end
    else if (ce)
    begin
      cmd_ready <= ((state_q == HS_IDLE) || (state_q == HS_HOLD)) && !take;
      sleeping <= (state_q == HS_HOLD) && !take;
    end
  end
endmodule

// >>> rtl/adc_link_if.sv
// two-wire link between host and converter: serial clock and ready/data
`timescale 1ns/1ps
interface adc_link_if;
  logic sclk;
  logic rdy_dout;

  modport dev (
    input sclk,
    output rdy_dout
  );

  modport host (
    output sclk,
    input rdy_dout
  );
endinterface

// >>> rtl/adc_link_pkg.sv
// shared constants, types and helpers for the two-wire converter link
package adc_link_pkg;

  // ****************************************************************
  // widths and edge counts
  // ****************************************************************
  localparam int WORD_W = 24;
  localparam logic [5:0] EDGE_LAST_BIT = 6'h18; // 24th rising edge
  localparam logic [5:0] EDGE_IDLE = 6'h19; // 25th rising edge
  localparam logic [5:0] EDGE_CAL = 6'h1a; // 26th rising edge
  localparam logic [5:0] EDGE_RST = 6'h00;

  // ****************************************************************
  // timing, in ns and in cycles of the 125 MHz clock
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 8;
  localparam int CONV_NS = 16384;
  localparam int CAL_NS = 8192;
  localparam int SLEEP_HOLD_NS = 512;
  localparam int HALF_NS = 128;
  localparam logic [11:0] CONV_CYC = 12'(CONV_NS / CLK_PERIOD_NS);
  localparam logic [11:0] CAL_CYC = 12'(CAL_NS / CLK_PERIOD_NS);
  localparam logic [11:0] SLEEP_CYC = 12'(SLEEP_HOLD_NS / CLK_PERIOD_NS);
  localparam logic [7:0] HALF_CYC = 8'(HALF_NS / CLK_PERIOD_NS);
  localparam logic [11:0] CNT_RST = 12'h000;

  // ****************************************************************
  // host read operations
  // ****************************************************************
  localparam logic [1:0] OP_READ = 2'h0; // 24 bits + 25th edge
  localparam logic [1:0] OP_READ_CAL = 2'h1; // 24 bits + 25th + 26th
  localparam logic [1:0] OP_READ_SLEEP = 2'h2; // 24 bits, then hold high
  localparam logic [1:0] OP_READ_CAL_SLEEP = 2'h3; // 25 edges, 26th held

  typedef enum logic [1:0] {
    DS_CAL = 2'b00,
    DS_RUN = 2'b01,
    DS_SLEEP = 2'b10
  } dev_state_t;

  typedef enum logic [2:0] {
    HS_IDLE = 3'b000,
    HS_WAIT = 3'b001,
    HS_HIGH = 3'b010,
    HS_LOW = 3'b011,
    HS_HOLD = 3'b100
  } host_state_t;

  // gray code helpers for the edge pointer
  function automatic logic [5:0] bin2gray(input logic [5:0] b);
    return b ^ (b >> 1);
  endfunction

  function automatic logic [5:0] gray2bin(input logic [5:0] g);
    logic [5:0] b;
    b[5] = g[5];
    for (int i = 4; i >= 0; i--)
    begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction

endpackage

// >>> rtl/pin_sync3.sv
// three-stage input synchroniser; output moves once stages two and three agree
`timescale 1ns/1ps
module pin_sync3 #(
  parameter logic RST = 1'b0
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic d,
  output logic q
);
  logic s1_q;
  logic s2_q;
  logic s3_q;

  // shift chain, first stage feeds only the second
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      s1_q <= RST;
      s2_q <= RST;
      s3_q <= RST;
    end
    else if (ce)
    begin
      s1_q <= d;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // accept a level once two stages agree
  always_ff @(posedge clk)
  begin
    if (!nrst)
      q <= RST;
    else if (ce && (s2_q == s3_q))
      q <= s3_q;
  end
endmodule

// >>> verification/adc_link_props.sv
// checker watching the serial clock and ready/data wires of the link
`timescale 1ns/1ps
module adc_link_props (
  input wire logic clk,
  input wire logic nrst,
  input wire logic sclk,
  input wire logic rdy_dout
);
  logic [7:0] hi_q;
  logic [7:0] lo_q;
  logic [7:0] age_q;
  logic [5:0] edge_q;
  logic cal_q;
  int wait_q;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  // **********
  // helpers
  // **********
  // phase lengths, age of last rise, rise count, pending calibration
  always_ff @(posedge clk)
  begin
    hi_q <= (!nrst || !sclk) ? 8'h00 : hi_q + 8'(hi_q != 8'hff);
    lo_q <= (!nrst || sclk) ? 8'h00 : lo_q + 8'(lo_q != 8'hff);
    age_q <= (!nrst || $rose(sclk)) ? 8'h00 : age_q + 8'(age_q != 8'hff);
    wait_q <= (!nrst || sclk || !rdy_dout) ? 0 : wait_q + 1;
    if (!nrst)
      edge_q <= 6'h00;
    else if ($rose(sclk))
      edge_q <= edge_q + 6'h01;
    else if (lo_q > 8'h14)
      edge_q <= 6'h00;
    if (!nrst)
      cal_q <= 1'b1;
    else if ($fell(sclk) && edge_q == 6'h1a)
      cal_q <= 1'b1;
    else if ($fell(rdy_dout))
      cal_q <= 1'b0;
  end

  // **********
  // properties
  // **********
  property p_reset_idle;
    $rose(nrst) |-> (rdy_dout && !sclk) [*8];
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("link not idle");

  property p_rise_src;
    $rose(rdy_dout) |-> sclk;
  endproperty
  a_rise_src: assert property (p_rise_src) else $error("rise without sclk");

  property p_fall_time;
    $fell(rdy_dout) && sclk |-> age_q < 8'h0c;
  endproperty
  a_fall_time: assert property (p_fall_time) else $error("late bit");

  property p_low_stable;
    !sclk && !$past(sclk) && edge_q inside {[6'h01:6'h18]} |-> $stable(rdy_dout);
  endproperty
  a_low_stable: assert property (p_low_stable) else $error("bit moved");

  property p_idle_25;
    edge_q == 6'h19 && age_q == 8'h0c |-> rdy_dout;
  endproperty
  a_idle_25: assert property (p_idle_25) else $error("no idle");

  property p_sleep;
    hi_q == 8'h40 |-> ##[1:12] rdy_dout [*8];
  endproperty
  a_sleep: assert property (p_sleep) else $error("no sleep");

  property p_conv_bound;
    wait_q < 3400;
  endproperty
  a_conv_bound: assert property (p_conv_bound) else $error("no data");

  property p_cal_len;
    $fell(rdy_dout) && cal_q |-> wait_q > 3000;
  endproperty
  a_cal_len: assert property (p_cal_len) else $error("short cal");
endmodule

// >>> verification/adc_two_wire_readout_tb_top.sv
// bench joining the host and converter ends across the link
`timescale 1ns/1ps
module adc_two_wire_readout_tb_top;
  import adc_link_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic ce = 1'b1;
  logic cmd_valid = 1'b0;
  logic [1:0] cmd_op = 2'h0;
  logic [WORD_W-1:0] sample_data = 24'h000000;
  logic conv_done, filt_rst, cal_busy, asleep, cmd_ready, result_valid, sleeping;
  logic [WORD_W-1:0] result;
  logic [WORD_W-1:0] wire_q = 24'h000000;
  logic sclk_p = 1'b0;
  logic wake_q = 1'b0;
  logic [WORD_W-1:0] exp_q[$];
  int n_mismatch = 0;
  int checks = 0;
  int seed = 32'h32a2c341;
  int i;
  logic [1:0] op;

  adc_link_if link ();
  adc_dev_end adc_dev_end_inst (.clk(clk), .nrst(nrst), .ce(ce), .link(link),
    .sample_data(sample_data), .conv_done(conv_done), .filt_rst(filt_rst),
    .cal_busy(cal_busy), .asleep(asleep));
  adc_host_end adc_host_end_inst (.clk(clk), .nrst(nrst), .ce(ce), .link(link),
    .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_ready(cmd_ready), .result(result),
    .result_valid(result_valid), .sleeping(sleeping));
  adc_link_props adc_link_props_inst (.clk(clk), .nrst(nrst), .sclk(link.sclk),
    .rdy_dout(link.rdy_dout));

  // clock
  always #4 clk = ~clk;

  task automatic chk(input logic [WORD_W-1:0] got, input logic [WORD_W-1:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  function automatic logic pick(input int s);
    return s == 0 ? conv_done : s == 1 ? cmd_ready : s == 2 ? cal_busy : asleep;
  endfunction

  // bounded wait for a flag, sampled at the falling edge
  task automatic wait_on(input int s, input int lim);
    int k = 0;
    @(negedge clk);
    while (pick(s) !== 1'b1 && k < lim)
    begin
      @(negedge clk);
      k++;
    end
    if (pick(s) !== 1'b1)
    begin
      n_mismatch++;
      $display("[ERR] t=%0t wait %h lim %h", $time, s, lim);
    end
  endtask

  task automatic send(input logic [1:0] o);
    wait_on(1, 100);
    cmd_valid = 1'b1;
    cmd_op = o;
    @(negedge clk);
    cmd_valid = 1'b0;
    wait_on(1, 6000);
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // compares each word from the port and from the wire, and filter resets
  always @(negedge clk)
  begin
    sclk_p <= link.sclk;
    if (sclk_p && !link.sclk)
      wire_q <= {wire_q[WORD_W-2:0], link.rdy_dout};
    if (result_valid === 1'b1)
    begin
      chk(result, exp_q[0]);
      chk(wire_q, exp_q.pop_front());
    end
    if (conv_done === 1'b1)
    begin
      chk({23'h0, filt_rst}, {23'h0, wake_q});
      wake_q <= 1'b0;
    end
  end

  // main sequence: every read mode, an overwrite, sleep and wake
  initial
  begin
    repeat (5) @(negedge clk);
    nrst = 1'b1;
    @(negedge clk);
    chk({23'h0, cal_busy}, 24'h000001);
    // frozen clock enable must stall calibration past its normal end
    repeat (1000) @(negedge clk);
    ce = 1'b0;
    repeat (200) @(negedge clk);
    chk({23'h0, cal_busy}, 24'h000001);
    ce = 1'b1;
    for (i = 0; i < 7; i++)
    begin
      op = i < 4 ? 2'(i) : 2'($random(seed));
      sample_data = 24'($random(seed));
      wait_on(0, 5000);
      if (i == 4)
      begin
        sample_data = 24'($random(seed));
        wait_on(0, 2100);
      end
      chk({23'h0, asleep}, 24'h000000);
      exp_q.push_back(sample_data);
      send(op);
      if (op == OP_READ_CAL)
        wait_on(2, 40);
      if (op[1])
      begin
        wait_on(3, 120);
        chk({22'h0, sleeping, link.rdy_dout}, 24'h000003);
        wake_q = 1'b1;
        send(2'h0);
        if (op[0])
          wait_on(2, 40);
      end
      $display("test %0d op %0d done", i, op);
    end
    chk(24'(exp_q.size()), 24'h000000);
    test_done();
  end

  // cuts a hung run short
  initial
  begin
    #800000;
    n_mismatch++;
    test_done();
  end
endmodule
